/* adcw_ctrl.sv */
// Converter flow control around MCU wait mode, with an APB register port.
// Assumes wait_req and sample_data are synchronous to ref_clk.
//
// Contract
// RULE_01: Select clear: keep converting through wait.
// RULE_02: Select set: party requests wait while idle.
// RULE_03: Wait during activity aborts after current conversion.
// RULE_04: Aborted result stored only with store-on-abort.
// RULE_05: Software abort: wait for abort-done first.
// RULE_06: Flow requests held clear during wait.
// RULE_07: Trigger mode exit: restart plus trigger.
// RULE_08: Restart mode exit: restart only, no abort.
// RULE_09: Result buffer select unchanged across wait.
// RULE_10: Type 10 wraps list, continues converting.
// RULE_11: Type 11 wraps list, then waits.
// RULE_12: No new conversion during wait.
`timescale 1ns/1ps
module adcw_ctrl #(
  parameter int CMD_DEPTH = 8,
  parameter int DW = 12,
  parameter int CONV_CYCLES = adcw_pkg::CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_req,
  input wire logic [DW-1:0] sample_data,
  output logic wait_ack,
  output logic irq
);
  localparam int IW = $clog2(CMD_DEPTH);

  // ****************************************
  // Register map.
  // ****************************************
  // Every register is one aligned word; unused upper bits read as zero.
  // Control holds the wait-stop select, store-on-abort, auto-restart and the
  // flow mode (clear for trigger mode, set for restart mode).
  // Flow requests are write-one-to-set; a read shows what is still pending.
  // Status bits are sticky and cleared by a read of the status word.
  // The mask word has the status layout and gates the level interrupt.
  // The state word packs the command index, the controller state, the
  // result buffer select, the wait hold and the result index.
  // The result word shows the last result that was stored.
  // Command type entries follow from the command base, one word apiece.
  // Unmapped addresses answer with an error, read as zero and ignore writes.
  // Limitation: the command memory has no reset, so software must fill the
  // list before the first trigger or the type decode sees unknown values.

  // ****************************************
  // State.
  // ****************************************
  adcw_pkg::adcw_state_t state_r, state_nxt;
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [3:0] flow_r, flow_nxt;
  logic [adcw_pkg::ST_WIDTH-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [IW-1:0] command_index_r, command_index_nxt;
  logic [7:0] result_index_r, result_index_nxt;
  logic result_buffer_select_r, result_buffer_select_nxt;
  logic armed_r, armed_nxt;
  logic [DW-1:0] result_r, result_nxt;
  logic [1:0] cmd_mem [CMD_DEPTH];
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, irq_nxt, wait_ack_nxt;
  logic conv_start, conv_busy, conv_done, hold, wait_exit;
  logic [DW-1:0] conv_result;
  logic acc, wr, rd, cmd_hit, known;
  logic [1:0] cmd_type;

  // ****************************************
  // Helpers.
  // ****************************************
  adcw_conv #(
    .CYCLES(CONV_CYCLES),
    .DW(DW)
  ) i_adcw_conv (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(conv_start),
    .sample(sample_data),
    .busy(conv_busy),
    .done(conv_done),
    .result(conv_result)
  );

  // The hold only rises with the stop select set, so with it clear the
  // conversion flow runs on through wait mode untouched.
  adcw_wait i_adcw_wait (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wait_req(wait_req),
    .stop_sel(ctrl_r[adcw_pkg::CTRL_WAIT_STOP]),
    .hold(hold),
    .exit_pulse(wait_exit)
  );

  // Transfers complete on the second access cycle, when pready is high.
  always_comb begin
    acc = psel & penable & pready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    cmd_hit = (paddr >= adcw_pkg::OFS_CMD_BASE) &&
              (paddr < adcw_pkg::OFS_CMD_BASE + 8'(4 * CMD_DEPTH)) &&
              (paddr[1:0] == 2'h0);
    known = cmd_hit || paddr == adcw_pkg::OFS_CTRL || paddr == adcw_pkg::OFS_FLOW ||
            paddr == adcw_pkg::OFS_STATUS || paddr == adcw_pkg::OFS_MASK ||
            paddr == adcw_pkg::OFS_STATE || paddr == adcw_pkg::OFS_RESULT;
    cmd_type = cmd_mem[command_index_r];
  end

  // ****************************************
  // Flow control.
  // ****************************************
  // One next-state process for all but the bus answer and the command list, so that priorities
  // between bus writes, wait mode and conversion events stay in one place.
  // Order of precedence, lowest first: bus writes, the automatic restart on
  // wait exit, the state machine consuming requests, and last the wait hold
  // that wipes every request. The hold therefore always wins, which keeps a
  // request written during wait from surviving until the exit.
  // A wait request during a conversion does not cut it short: with the stop
  // select set the state machine moves to the abort state and lets the running conversion end.
  always_comb begin
    logic rmode, trigger_request, rst, go;
    logic [adcw_pkg::ST_WIDTH-1:0] ev;
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    flow_nxt = flow_r;
    mask_nxt = mask_r;
    command_index_nxt = command_index_r;
    result_index_nxt = result_index_r;
    result_buffer_select_nxt = result_buffer_select_r;
    armed_nxt = armed_r;
    result_nxt = result_r;
    conv_start = 1'b0;
    ev = '0;
    rmode = ctrl_r[adcw_pkg::CTRL_RESTART_MODE];
    trigger_request = flow_r[adcw_pkg::FLOW_TRIGGER];
    rst = flow_r[adcw_pkg::FLOW_RESTART];
    go = 1'b0;
    if (wr && paddr == adcw_pkg::OFS_CTRL) begin
      ctrl_nxt = pwdata[3:0];
    end
    if (wr && paddr == adcw_pkg::OFS_MASK) begin
      mask_nxt = pwdata[adcw_pkg::ST_WIDTH-1:0];
    end
    // Software sets requests by writing ones; hardware consumes them.
    if (wr && paddr == adcw_pkg::OFS_FLOW) begin
      flow_nxt = flow_r | pwdata[3:0];
    end
    // Automatic restart on leaving wait mode.
    if (wait_exit && ctrl_r[adcw_pkg::CTRL_AUTO_RESTART]) begin
      flow_nxt[adcw_pkg::FLOW_RESTART] = 1'b1; // RULE_07 RULE_08
      flow_nxt[adcw_pkg::FLOW_TRIGGER] = ~rmode; // RULE_07
      flow_nxt[adcw_pkg::FLOW_ABORT] = 1'b0; // RULE_08
    end
    case (state_r)
      adcw_pkg::ST_IDLE: begin
        // A pending abort with nothing running completes at once.
        if (flow_r[adcw_pkg::FLOW_ABORT]) begin
          flow_nxt[adcw_pkg::FLOW_ABORT] = 1'b0;
          ev[adcw_pkg::ST_ABORT_DONE] = 1'b1;
        end
        if (rst) begin
          // Restart runs before any trigger taken in the same cycle.
          command_index_nxt = '0; // RULE_07 RULE_08
          result_index_nxt = 8'h00;
          flow_nxt[adcw_pkg::FLOW_RESTART] = 1'b0;
          armed_nxt = 1'b1;
        end
        // Restart mode needs restart then trigger; trigger mode takes either.
        go = rmode ? (trigger_request & (armed_r | rst)) : (trigger_request | rst); // RULE_07 RULE_08
        if (go && !hold) begin // RULE_12
          flow_nxt[adcw_pkg::FLOW_TRIGGER] = 1'b0;
          armed_nxt = 1'b0;
          conv_start = 1'b1;
          state_nxt = adcw_pkg::ST_CONV;
        end
      end
      adcw_pkg::ST_CONV: begin
        // Wait entry with stop select set turns into a sequence abort.
        if (hold || flow_r[adcw_pkg::FLOW_ABORT] || rst) begin // RULE_03
          state_nxt = adcw_pkg::ST_ABORT;
        end else if (conv_done) begin // RULE_01
          result_nxt = conv_result;
          result_index_nxt = result_index_r + 8'h01;
          ev[adcw_pkg::ST_CONV_DONE] = 1'b1;
          if (cmd_type == adcw_pkg::CMD_EOL_CONT || cmd_type == adcw_pkg::CMD_EOL_WAIT) begin
            command_index_nxt = '0;
            result_index_nxt = 8'h00;
            ev[adcw_pkg::ST_LIST_END] = 1'b1;
            // Buffers swap only at list end with load ok given.
            if (flow_r[adcw_pkg::FLOW_LOAD_OK]) begin
              result_buffer_select_nxt = ~result_buffer_select_r;
              flow_nxt[adcw_pkg::FLOW_LOAD_OK] = 1'b0;
            end
          end else begin
            command_index_nxt = command_index_r + IW'(1);
          end
          if (cmd_type == adcw_pkg::CMD_EOL_WAIT) begin
            state_nxt = adcw_pkg::ST_IDLE; // RULE_11
          end else begin
            conv_start = 1'b1; // RULE_10
          end
        end
      end
      adcw_pkg::ST_ABORT: begin
        // The conversion under way is allowed to finish. If the abort was
        // taken in the very cycle that a conversion ended, the done pulse is
        // already gone; the idle timer then ends the abort at once, else the
        // controller would sit in this state for ever.
        if (conv_done || !conv_busy) begin // RULE_03
          if (ctrl_r[adcw_pkg::CTRL_STORE_ABORT]) begin // RULE_04
            result_nxt = conv_result;
            result_index_nxt = result_index_r + 8'h01;
            ev[adcw_pkg::ST_CONV_DONE] = 1'b1;
          end
          flow_nxt[adcw_pkg::FLOW_ABORT] = 1'b0;
          ev[adcw_pkg::ST_ABORT_DONE] = 1'b1; // RULE_05
          state_nxt = adcw_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = adcw_pkg::ST_IDLE;
      end
    endcase
    // While held in wait mode all requests stay clear; the buffer select
    // is left alone so the same buffer resumes after exit.
    if (hold) begin
      flow_nxt = 4'h0; // RULE_06 RULE_09
    end
    // Events win over the read that clears them.
    stat_nxt = ((rd && paddr == adcw_pkg::OFS_STATUS) ? '0 : stat_r) | ev;
  end

  // Command list writes; the memory is not reset, to keep it plain storage.
  always_ff @(posedge ref_clk) begin
    if (wr && cmd_hit) begin
      cmd_mem[paddr[IW+1:2]] <= pwdata[1:0];
    end
  end

  // ****************************************
  // Bus answer and interrupt.
  // ****************************************
  // Read data is built in the first access cycle and shown with pready.
  // The one wait state lets read data come straight from a flip-flop, at
  // the cost of one extra cycle per transfer. Outside the answer cycle the
  // read data stays zero, so a stale value can never be mistaken for data.
  always_comb begin
    pready_nxt = psel & penable & ~pready;
    pslverr_nxt = pready_nxt & ~known;
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt && !pwrite) begin
      if (cmd_hit) begin
        prdata_nxt = {30'h0, cmd_mem[paddr[IW+1:2]]};
      end else begin
        case (paddr)
          adcw_pkg::OFS_CTRL: prdata_nxt = {28'h0, ctrl_r};
          adcw_pkg::OFS_FLOW: prdata_nxt = {28'h0, flow_r};
          adcw_pkg::OFS_STATUS: prdata_nxt = {29'h0, stat_r};
          adcw_pkg::OFS_MASK: prdata_nxt = {29'h0, mask_r};
          adcw_pkg::OFS_STATE: prdata_nxt = {8'h0, result_index_r, 3'h0, hold,
                                              1'b0, result_buffer_select_r,
                                              state_r, 8'(command_index_r)};
          adcw_pkg::OFS_RESULT: prdata_nxt = 32'(result_r);
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    irq_nxt = |(stat_nxt & mask_nxt);
    // Safe to enter wait once nothing runs and no conversion is busy.
    wait_ack_nxt = (state_nxt == adcw_pkg::ST_IDLE) & ~conv_busy; // RULE_02
  end

  // Registers only. The reset is synchronous, so the first bus setup may
  // follow on the first edge after release.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= adcw_pkg::ST_IDLE;
      ctrl_r <= adcw_pkg::CTRL_RESET;
      flow_r <= 4'h0;
      stat_r <= '0;
      mask_r <= '0;
      command_index_r <= '0;
      result_index_r <= 8'h00;
      result_buffer_select_r <= 1'b0;
      armed_r <= 1'b0;
      result_r <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      wait_ack <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      flow_r <= flow_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      command_index_r <= command_index_nxt;
      result_index_r <= result_index_nxt;
      result_buffer_select_r <= result_buffer_select_nxt;
      armed_r <= armed_nxt;
      result_r <= result_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      irq <= irq_nxt;
      wait_ack <= wait_ack_nxt;
    end
  end
endmodule

/* adcw_pkg.sv */
// Shared constants of the converter wait-mode flow control block.
// Assumes a 50 MHz bus clock and a 32-bit APB register port.
package adcw_pkg;
  // ****************************************
  // Timing.
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS = 1000;
  // A least time, so round up.
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // Register map, byte addresses.
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLOW = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_CMD_BASE = 8'h40;
  // Control fields.
  localparam int CTRL_WAIT_STOP = 0;
  localparam int CTRL_STORE_ABORT = 1;
  localparam int CTRL_AUTO_RESTART = 2;
  localparam int CTRL_RESTART_MODE = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Flow request fields.
  localparam int FLOW_TRIGGER = 0;
  localparam int FLOW_RESTART = 1;
  localparam int FLOW_ABORT = 2;
  localparam int FLOW_LOAD_OK = 3;
  // Status and mask fields.
  localparam int ST_ABORT_DONE = 0;
  localparam int ST_CONV_DONE = 1;
  localparam int ST_LIST_END = 2;
  localparam int ST_WIDTH = 3;
  // Command type select encodings.
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_EOL_CONT = 2'h2;
  localparam logic [1:0] CMD_EOL_WAIT = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ABORT} adcw_state_t;
endpackage

/* adcw_conv.sv */
// Conversion timer: one conversion takes a fixed number of bus clocks.
// Assumes the sample input is stable while a conversion is under way.
`timescale 1ns/1ps
module adcw_conv #(
  parameter int CYCLES = adcw_pkg::CONV_CYCLES,
  parameter int DW = 12
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [DW-1:0] sample,
  output logic busy,
  output logic done,
  output logic [DW-1:0] result
);
  // ****************************************
  // Counter.
  // ****************************************
  logic [15:0] cnt_r, cnt_nxt;
  logic busy_nxt, done_nxt;
  logic [DW-1:0] result_nxt;

  // A start while busy is ignored; the controller never asks for one.
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy;
    done_nxt = 1'b0;
    result_nxt = result;
    if (busy) begin
      if (cnt_r == 16'h0001) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        result_nxt = sample;
      end
      cnt_nxt = cnt_r - 16'h0001;
    end else if (start) begin
      busy_nxt = 1'b1;
      cnt_nxt = 16'(CYCLES);
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      busy <= busy_nxt;
      done <= done_nxt;
      result <= result_nxt;
    end
  end
endmodule

/* adcw_wait.sv */
// Wait-mode tracker: holds the wait state and marks the exit from it.
// Assumes the wait request is a level synchronous to the bus clock.
`timescale 1ns/1ps
module adcw_wait (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wait_req,
  input wire logic stop_sel,
  output logic hold,
  output logic exit_pulse
);
  // ****************************************
  // Wait state.
  // ****************************************
  logic hold_nxt, exit_nxt;

  // Hold only counts while the stop select is set; exit is its fall when the wait request drops.
  always_comb begin
    hold_nxt = wait_req & stop_sel;
    exit_nxt = hold & ~wait_req;
  end

  // Registers only.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hold <= 1'b0;
      exit_pulse <= 1'b0;
    end else begin
      hold <= hold_nxt;
      exit_pulse <= exit_nxt;
    end
  end
endmodule

/* adcw_ctrl_chk.sv */
// Concurrent checks on the ports of the converter wait-mode flow control block.
// Assumes it is bound to adcw_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module adcw_ctrl_chk #(
  parameter int CONV_CYCLES = adcw_pkg::CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wait_req,
  input wire logic wait_ack,
  input wire logic irq
);
  // The rest of one conversion plus the request lag, with a little margin.
  localparam int ABORT_MAX = CONV_CYCLES + 8;
  logic wr_ok;
  logic ws_r;
  logic ws_nxt;
  logic [2:0] mask_r;
  logic [2:0] mask_nxt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // Shadow registers.
  // ****************************************
  // Select and mask are shadowed from completed writes, since only ports are visible.
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  always_comb begin
    ws_nxt = ws_r;
    mask_nxt = mask_r;
    if (wr_ok && paddr == adcw_pkg::OFS_CTRL) ws_nxt = pwdata[adcw_pkg::CTRL_WAIT_STOP];
    if (wr_ok && paddr == adcw_pkg::OFS_MASK) mask_nxt = pwdata[2:0];
  end
  // The shadows follow the design's own reset.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ws_r <= 1'b0;
      mask_r <= 3'h0;
    end else begin
      ws_r <= ws_nxt;
      mask_r <= mask_nxt;
    end
  end
  // ****************************************
  // Properties.
  // ****************************************
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_held;
    ws_r && wait_req && $past(wait_req) && $past(wait_req, 2) && $past(wait_req, 3);
  endsequence
  property p_rdy_wait;
    s_setup ##1 s_access |=> pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("pready not on second access cycle");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("pready longer than one cycle");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("pslverr without pready");
  property p_rd_zero;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("prdata not zero outside a response");
  property p_irq_off;
    (mask_r == 3'h0 && $past(mask_r) == 3'h0) |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq high with everything masked");
  property p_flow_clr;
    (s_held and (pready && !pwrite && paddr == adcw_pkg::OFS_FLOW)) |-> prdata[3:0] == 4'h0;
  endproperty
  a_flow_clr: assert property (p_flow_clr)
    else $error("flow request pending during wait");
  property p_no_start;
    (s_held and wait_ack) ##1 wait_req |-> wait_ack;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("conversion started during wait");
  property p_abort_fin;
    (ws_r && $rose(wait_req)) |-> ##[1:ABORT_MAX] (wait_ack || !wait_req);
  endproperty
  a_abort_fin: assert property (p_abort_fin)
    else $error("abort on wait request too slow");
endmodule

/* adcw_pmu_model.sv */
// Stand-in for the MCU power mode control that requests wait mode.
// Assumes wait_ack means the converter is idle; runs on the bus clock.
`timescale 1ns/1ps
module adcw_pmu_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic rude,
  input wire logic wait_ack,
  output logic wait_req
);
  // A polite request waits for an idle converter; a rude one does not, to provoke the abort.
  always_ff @(posedge ref_clk) begin
    if (!rstn || !go) begin
      wait_req <= 1'b0;
    end else if (rude || wait_ack) begin
      wait_req <= 1'b1;
    end
  end
endmodule

/* test_adc_wait_mode_flow_control.sv */
// Self-checking bench for the converter wait-mode flow control block.
// Assumes the package, design, checker and partner model are compiled first.
`timescale 1ns/1ps
module test_adc_wait_mode_flow_control;
  localparam int CC = 20;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, wait_req, wait_ack, irq, go, rude;
  logic qe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] sample_data;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  adcw_ctrl #(.CONV_CYCLES(CC)) i_adcw_ctrl (.ref_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_req, .sample_data, .wait_ack, .irq);
  adcw_pmu_model i_adcw_pmu_model (.ref_clk, .rstn, .go, .rude, .wait_ack, .wait_req);
  // ****************************************
  // Clock and hang guard.
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // ****************************************
  // Bus tasks, entered and left just after a rising edge.
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    qe = pslverr;
    check("pready", pready, 1'b1);
    check("pready lag", n, 32'h2);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic ack_is(input logic v);
    int n;
    n = 0;
    while (wait_ack !== v && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check("wait_ack", wait_ack, v);
  endtask
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic s_list();
    rd(8'hFC);
    check("unmapped", {qe, q[30:0]}, 32'h80000000);
    wr(adcw_pkg::OFS_CMD_BASE, 32'(adcw_pkg::CMD_NORMAL));
    wr(adcw_pkg::OFS_CMD_BASE + 8'h04, 32'(adcw_pkg::CMD_EOL_CONT));
    wr(adcw_pkg::OFS_MASK, 32'h2);
    // Trigger plus load ok: the first list end swaps the result buffer.
    wr(adcw_pkg::OFS_FLOW, 32'h9);
    go <= 1'b1;
    rude <= 1'b1;
    repeat (4 * CC) @(posedge ref_clk);
    check("irq", irq, 1'b1);
    rd(adcw_pkg::OFS_STATUS);
    repeat (4 * CC) @(posedge ref_clk);
    rd(adcw_pkg::OFS_STATUS);
    check("conv on", q[1], 1'b1);
    rd(adcw_pkg::OFS_RESULT);
    check("result", q, 32'h5A5);
    go <= 1'b0;
    wr(adcw_pkg::OFS_CMD_BASE + 8'h04, 32'(adcw_pkg::CMD_EOL_WAIT));
    ack_is(1'b1);
    rd(adcw_pkg::OFS_STATUS);
    check("list end", q[2], 1'b1);
    rd(adcw_pkg::OFS_STATE);
    check("state", q[9:0], 10'h0);
    check("swap", q[10], 1'b1);
    @(posedge ref_clk);
    check("irq clr", irq, 1'b0);
  endtask
  task automatic s_abort(input logic keep);
    wr(adcw_pkg::OFS_CTRL, {30'h0, keep, 1'b1});
    wr(adcw_pkg::OFS_MASK, 32'h0);
    rd(adcw_pkg::OFS_STATUS);
    sample_data <= 12'h3C3;
    // Load ok rides along; the abort must drop it without a buffer swap.
    wr(adcw_pkg::OFS_FLOW, 32'h9);
    go <= 1'b1;
    ack_is(1'b0);
    ack_is(1'b1);
    wr(adcw_pkg::OFS_FLOW, 32'h1);
    rd(adcw_pkg::OFS_FLOW);
    check("flow", q[3:0], 4'h0);
    check("no start", wait_ack, 1'b1);
    rd(adcw_pkg::OFS_STATE);
    check("buffer kept", q[10], 1'b1);
    rd(adcw_pkg::OFS_RESULT);
    check("result", q, keep ? 32'h3C3 : 32'h5A5);
    rd(adcw_pkg::OFS_STATUS);
    check("status", q[1:0], {keep, 1'b1});
    check("irq mask", irq, 1'b0);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic s_exit(input logic rmode);
    logic b;
    wr(adcw_pkg::OFS_CTRL, {28'h0, rmode, 3'h5});
    rd(adcw_pkg::OFS_STATUS);
    rd(adcw_pkg::OFS_STATE);
    b = q[10];
    go <= 1'b1;
    rude <= 1'b0;
    // The hold settles one cycle after the request; leave margin.
    repeat (4) @(posedge ref_clk);
    go <= 1'b0;
    if (!rmode) begin
      ack_is(1'b0);
    end else begin
      repeat (2 * CC) @(posedge ref_clk);
      check("idle", wait_ack, 1'b1);
      wr(adcw_pkg::OFS_FLOW, 32'h1);
      ack_is(1'b0);
    end
    ack_is(1'b1);
    rd(adcw_pkg::OFS_STATUS);
    check("status", q[1:0], 2'b10);
    rd(adcw_pkg::OFS_STATE);
    check("buffer", q[10], b);
  endtask
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    {psel, penable, pwrite, go, rude, rstn} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sample_data = 12'h5A5;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    s_list();
    s_abort(1'b0);
    s_abort(1'b1);
    s_exit(1'b0);
    s_exit(1'b1);
    wrap_up();
  end
endmodule
bind adcw_ctrl adcw_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.ref_clk, .rstn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_req, .wait_ack, .irq);
